// ==== dss_bit_source.sv ====
// Upstream bit encoder model offering random bits with random gaps
`timescale 1ns/1ps
module dss_bit_source (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic active,
    input  wire logic bit_ready,
    output logic      bit_valid,
    output logic      bit_data
);
    // ====================
    // Offer and hold
    // An offer stays put until taken; an idle data line toggles so that
    // nothing downstream can lean on a stale bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_valid <= 1'b0;
            bit_data  <= 1'b0;
        end else if (bit_valid && !(bit_ready && ce)) begin
            bit_valid <= 1'b1;
        end else if (active && ($urandom % 4 != 0)) begin
            bit_valid <= 1'b1;
            bit_data  <= 1'($urandom);
        end else begin
            bit_valid <= 1'b0;
            bit_data  <= ~bit_data;
        end
    end
endmodule : dss_bit_source

// ==== dss_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dss_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [3:0]       level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;
    logic [3:0]       next_level;

    // ==========================================================
    // Handshake decode
    assign push       = ce && in_valid && in_ready;
    assign pop        = ce && out_valid && out_ready;
    assign out_valid  = level != 4'h0;
    assign out_data   = mem[rd_ptr];
    assign next_level = level + {3'h0, push} - {3'h0, pop};

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, level and a registered ready
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            level    <= 4'h0;
            in_ready <= 1'b1;
        end else if (ce) begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            level    <= next_level;
            in_ready <= next_level != 4'(DEPTH);
        end
    end

    a_fifo_full: assert property (@(posedge clk) disable iff (!reset_n)
        level == 4'(DEPTH) |-> !in_ready)
        else $error("ready while full");

endmodule : dss_fifo

// ==== dss_msequence.sv ====
// One Fibonacci maximum-length sequence generator
`timescale 1ns/1ps
module dss_msequence
    import dss_pkg::*;
#(
    parameter logic [24:0] TAPS = TAPS_FIRST
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        load,
    input  wire logic [24:0] init,
    input  wire logic        step,
    output logic      [24:0] state,
    output logic             seq_bit
);

    // ==========================================================
    // Shift register, stage 0 is the output
    logic fb;
    assign fb      = ^(state & TAPS);
    assign seq_bit = state[0];

    // Load wins over step so a restart lands cleanly
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= FIRST_INIT;  // Nonzero, so a missed restart still runs
        end else if (ce) begin
            if (load) begin
                state <= init;
            end else if (step) begin
                state <= {fb, state[24:1]};
            end
        end
    end

    a_shift_step: assert property (@(posedge clk) disable iff (!reset_n)
        ce && step && !load |=> state[23:0] == $past(state[24:1]))
        else $error("generator did not shift");

endmodule : dss_msequence

// ==== dss_pkg.sv ====
// Constants, types and helpers shared by the chip spreader files
package dss_pkg;

    // ==========================================================
    // Sequence generators
    localparam int          LFSR_LEN    = 25;
    localparam logic [24:0] TAPS_FIRST  = 25'h0000009;  // x^25+x^3+1
    localparam logic [24:0] TAPS_SECOND = 25'h000000F;  // x^25+x^3+x^2+x+1
    localparam logic [24:0] FIRST_INIT  = 25'h0000001;

    // ==========================================================
    // Register map (byte addresses)
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_GINIT  = 12'h004;
    localparam logic [11:0] ADDR_OVSF   = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;

    // Control fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_OQPSK   = 1;
    localparam int CTRL_RESTART = 2;
    localparam int CTRL_SF_LSB  = 4;
    localparam int SF_LOG_W     = 3;
    localparam int IDX_W        = 7;

    // Status fields
    localparam int STAT_BUSY      = 0;
    localparam int STAT_PARITY    = 1;
    localparam int STAT_LEVEL_LSB = 8;

    // Reset values
    localparam logic [2:0]  SF_LOG_RST = 3'h3;
    localparam logic [24:0] GINIT_RST  = 25'h0000001;
    localparam logic [6:0]  OVSF_RST   = 7'h00;

    // ==========================================================
    // Sequencer states
    typedef enum logic {
        DSS_IDLE = 1'b0,
        DSS_RUN  = 1'b1
    } dss_state_t;

    // Product of two +1/-1 values coded as 1/0
    function automatic logic dss_mul(input logic a, input logic b);
        return ~(a ^ b);
    endfunction : dss_mul

    // Chip k of the recursively built orthogonal code
    function automatic logic dss_ovsf(input logic [6:0] k, input logic [6:0] sel);
        return ~(^(k & sel));
    endfunction : dss_ovsf

endpackage : dss_pkg

// ==== dss_spreader.sv ====
// Direct-sequence chip spreader with gold and orthogonal codes
//
// How it works
// - Bit zero becomes symbol +1, bit one becomes symbol -1.
// - Each symbol is held for exactly spreading_factor chips.
// - Repeated symbol is multiplied chip by chip with the gold code.
// - Any equivalent of repeat-then-multiply is fine; no literal up-sampler.
// - Gold chip is XOR of both generator outputs.
// - Both generators are 25-stage Fibonacci shift registers.
// - Polynomials are x^25+x^3+1 and x^25+x^3+x^2+x+1.
// - First generator loads 0x1, second loads a programmable vector.
// - Gold sequence repeats after 33,554,431 chips.
// - Gold is the primary code; orthogonal code also applied per network.
// - Orthogonal code built from [1], appending copy or negated copy.
// - BPSK: chip one is positive pulse, chip zero negative.
// - Chip zero goes first, chip spreading_factor-1 last, each symbol.
// - O-QPSK even symbol: even chips on I, odd chips on Q.
// - O-QPSK odd symbol: even chips on Q, odd chips on I.
// - Q rail lags I rail by one chip period.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module dss_spreader
    import dss_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bit_valid,
    input  wire logic        bit_data,
    output logic             bit_ready,
    output logic             chip_valid,
    output logic             chip_bpsk,
    output logic             chip_i,
    output logic             chip_q,
    output logic             sym_start
);

    // ==========================================================
    // Register state
    logic                enable;
    logic                oqpsk;
    logic [SF_LOG_W-1:0] sf_log;
    logic [24:0]         gold_init;
    logic [IDX_W-1:0]    ovsf_sel;
    logic                restart;

    // Sequencer state
    dss_state_t       state;
    logic             sym_bit;
    logic [IDX_W-1:0] chip_idx;
    logic             sym_par;
    logic             q_stage;

    // Internal nets
    logic             fifo_valid;
    logic             fifo_data;
    logic [3:0]       fifo_level;
    logic             take;
    logic             last_chip;
    logic [IDX_W-1:0] sf_last;
    logic             gold;
    logic             ovsf;
    logic             chip_now;
    logic             to_i;
    logic             running;
    logic             seq1_bit;
    logic             seq2_bit;
    logic [24:0]      seq1_state;
    logic [24:0]      seq2_state;
    logic             apb_setup;
    logic             apb_write;
    logic [31:0]      next_rdata;
    logic             next_err;

    // ==========================================================
    // APB slave: no wait states, pready raised in the first access cycle
    assign apb_setup = psel && !penable && !pready;
    assign apb_write = psel && penable && pready && pwrite;

    // Read mux and unmapped decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        unique case (paddr)
            ADDR_CTRL: begin
                next_rdata[CTRL_EN]    = enable;
                next_rdata[CTRL_OQPSK] = oqpsk;
                next_rdata[CTRL_SF_LSB +: SF_LOG_W] = sf_log;
            end
            ADDR_GINIT: begin
                next_rdata[24:0] = gold_init;
            end
            ADDR_OVSF: begin
                next_rdata[IDX_W-1:0] = ovsf_sel;
            end
            ADDR_STATUS: begin
                next_rdata[STAT_BUSY]   = running;
                next_rdata[STAT_PARITY] = sym_par;
                next_rdata[STAT_LEVEL_LSB +: 4] = fifo_level;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // Answer flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= apb_setup;
            pslverr <= apb_setup && next_err;
            if (apb_setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // Configuration writes; restart is a self-clearing strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable    <= 1'b0;
            oqpsk     <= 1'b0;
            sf_log    <= SF_LOG_RST;
            gold_init <= GINIT_RST;
            ovsf_sel  <= OVSF_RST;
            restart   <= 1'b0;
        end else if (ce) begin
            restart <= 1'b0;
            if (apb_write && paddr == ADDR_CTRL) begin
                enable  <= pwdata[CTRL_EN];
                oqpsk   <= pwdata[CTRL_OQPSK];
                sf_log  <= pwdata[CTRL_SF_LSB +: SF_LOG_W];
                restart <= pwdata[CTRL_RESTART];
            end
            if (apb_write && paddr == ADDR_GINIT) begin
                gold_init <= pwdata[24:0];
            end
            if (apb_write && paddr == ADDR_OVSF) begin
                ovsf_sel <= pwdata[IDX_W-1:0];
            end
        end
    end

    // ==========================================================
    // Input buffer between the bit encoder and the sequencer
    dss_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .in_valid  (bit_valid),
        .in_ready  (bit_ready),
        .in_data   (bit_data),
        .out_valid (fifo_valid),
        .out_ready (take),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    // ==========================================================
    // Gold code: both generators step once per emitted chip
    dss_msequence #(
        .TAPS (TAPS_FIRST)
    ) u_first_msequence_generator (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .load    (restart),
        .init    (FIRST_INIT),
        .step    (running),
        .state   (seq1_state),
        .seq_bit (seq1_bit)
    );

    dss_msequence #(
        .TAPS (TAPS_SECOND)
    ) u_second_msequence_generator (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .load    (restart),
        .init    (gold_init),
        .step    (running),
        .state   (seq2_state),
        .seq_bit (seq2_bit)
    );

    // Both generators are maximal length, so the pair repeats every 2^25-1 chips
    assign gold = seq1_bit ^ seq2_bit;

    // ==========================================================
    // Chip arithmetic, computed in place instead of up-sampling
    assign running   = state == DSS_RUN;
    assign sf_last   = IDX_W'((8'h01 << sf_log) - 8'h01);
    assign last_chip = chip_idx == sf_last;
    assign ovsf      = dss_ovsf(chip_idx, ovsf_sel);
    assign chip_now  = dss_mul(dss_mul(sym_bit, gold), ovsf);
    assign to_i      = !(chip_idx[0] ^ sym_par);

    // A symbol is taken only when idle or during its last chip
    assign take = ce && enable && !restart && fifo_valid && (!running || last_chip);

    // ==========================================================
    // Symbol sequencer; changing the factor mid-symbol ends that symbol when chip_idx next equals the new last index
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= DSS_IDLE;
            sym_bit  <= 1'b1;
            chip_idx <= '0;
            sym_par  <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                state    <= DSS_IDLE;
                chip_idx <= '0;
                sym_par  <= 1'b0;
            end else if (take) begin
                state    <= DSS_RUN;
                sym_bit  <= ~fifo_data;
                chip_idx <= '0;
                if (running) sym_par <= ~sym_par;
            end else if (running) begin
                if (last_chip) begin
                    state    <= DSS_IDLE;
                    chip_idx <= '0;
                    sym_par  <= ~sym_par;
                end else begin
                    chip_idx <= chip_idx + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Output rails; Q passes an extra stage for the offset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_valid <= 1'b0;
            chip_bpsk  <= 1'b0;
            chip_i     <= 1'b0;
            chip_q     <= 1'b0;
            q_stage    <= 1'b0;
            sym_start  <= 1'b0;
        end else if (ce) begin
            chip_valid <= running;
            sym_start  <= running && chip_idx == '0;
            if (running) begin
                chip_bpsk <= chip_now;
                if (!oqpsk || to_i) begin
                    chip_i <= chip_now;
                end else begin
                    q_stage <= chip_now;
                end
                chip_q <= q_stage;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_symbol_take;
        ce && take;
    endsequence

    sequence s_first_chip;
        running && chip_idx == '0;
    endsequence

    a_symbol_start: assert property (@(posedge clk) disable iff (!reset_n)
        s_symbol_take |=> s_first_chip)
        else $error("symbol did not start at chip zero");

    a_symbol_hold: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && !last_chip && !restart |=> $stable(sym_bit))
        else $error("symbol changed inside its period");

    a_symbol_map: assert property (@(posedge clk) disable iff (!reset_n)
        s_symbol_take |=> sym_bit == !$past(fifo_data))
        else $error("bit to symbol mapping wrong");

    a_chip_count: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && !last_chip && !restart |=> chip_idx == $past(chip_idx) + 1'b1)
        else $error("chip index skipped");

    a_gold_xor: assert property (@(posedge clk) disable iff (!reset_n)
        gold == (seq1_state[0] ^ seq2_state[0]))
        else $error("gold chip not XOR of generators");

    a_first_load: assert property (@(posedge clk) disable iff (!reset_n)
        ce && restart |=> seq1_state == FIRST_INIT && seq2_state == $past(gold_init))
        else $error("generator load value wrong");

    a_first_nonzero: assert property (@(posedge clk) disable iff (!reset_n)
        seq1_state != 25'h0000000)
        else $error("first generator locked at zero");

    a_bpsk_chip: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running |=> chip_valid && chip_bpsk == $past(chip_now))
        else $error("bpsk chip wrong");

    a_spread_value: assert property (@(posedge clk) disable iff (!reset_n)
        running |-> chip_now == (sym_bit ^ gold ^ ovsf))
        else $error("chip product wrong");

    a_oqpsk_route: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && oqpsk && to_i |=> chip_i == $past(chip_now))
        else $error("chip not routed to I rail");

    a_q_lag: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && oqpsk && !to_i ##1 ce && running |=> chip_q == $past(chip_now, 2))
        else $error("Q rail not one chip late");

    // Rails, parity and idle valid, guarded one step ahead of the output flops
    a_bpsk_rail: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && !oqpsk |=> chip_i == $past(chip_now))
        else $error("I rail differs from bpsk chip");

    a_q_stage_load: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && oqpsk && !to_i |=> q_stage == $past(chip_now))
        else $error("Q chip not staged");

    a_par_flip: assert property (@(posedge clk) disable iff (!reset_n)
        ce && running && last_chip && !restart |=> sym_par != $past(sym_par))
        else $error("symbol parity did not advance");

    a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !running |=> !chip_valid)
        else $error("chip valid while idle");

endmodule : dss_spreader

// ==== tb.sv ====
// Self-checking bench for the chip spreader
`timescale 1ns/1ps
module tb
    import dss_pkg::*;
;
    // ====================
    // Signals
    logic        clk, reset_n, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, bit_valid, bit_data, bit_ready;
    logic        chip_valid, chip_bpsk, chip_i, chip_q, sym_start;
    logic        src_on, ce_rand;
    logic [24:0] m_s1, m_s2, cfg_gi;
    logic [6:0]  cfg_ovsf;
    logic [2:0]  cfg_sf;
    logic        cfg_oq, m_par, m_pend, m_qexp, m_bit, m_exp, m_ce;
    logic        bitq[$];
    int          m_k, n_errors, total_checks, cfg_gen, m_gen;

    dss_spreader #(.FIFO_DEPTH(8)) i_dss_spreader (
        .clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_valid(bit_valid),
        .bit_data(bit_data), .bit_ready(bit_ready), .chip_valid(chip_valid),
        .chip_bpsk(chip_bpsk), .chip_i(chip_i), .chip_q(chip_q),
        .sym_start(sym_start)
    );

    dss_bit_source i_dss_bit_source (
        .clk(clk), .reset_n(reset_n), .ce(ce), .active(src_on),
        .bit_ready(bit_ready), .bit_valid(bit_valid), .bit_data(bit_data)
    );

    // ====================
    // Clock and clock enable
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Random enable gaps only while no bus transfer is pending
    always @(posedge clk) begin
        ce <= ce_rand ? ($urandom % 4 != 0) : 1'b1;
    end

    // ====================
    // Compare and report
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // ====================
    // Register bus
    // One idle edge first, so a release is never reassigned in its own step
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic perr);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            complete_run();
        end
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp,
                          input logic [31:0] mask);
        apb(1'b0, addr, 32'h00000000, rd, err);
        chk_bit("pslverr", 1'b0, err);
        chk_word("read", exp, rd & mask);
    endtask : rd_chk

    // Polls until the buffer is empty and the sequencer idle
    task automatic wait_idle();
        int i;
        for (i = 0; i < 1000; i++) begin
            apb(1'b0, ADDR_STATUS, 32'h00000000, rd, err);
            if ((rd & 32'h00000F01) === 32'h00000000) break;
        end
        if (i == 1000) begin
            n_errors++;
            complete_run();
        end
        repeat (4) @(posedge clk);
    endtask : wait_idle

    // Programs a code set and restarts; the reference restarts with it
    task automatic start_cfg(input logic [2:0] sf, input logic oq, input logic [24:0] gi,
                             input logic [6:0] ov, input logic en);
        apb(1'b1, ADDR_GINIT, {7'h00, gi}, rd, err);
        rd_chk(ADDR_GINIT, {7'h00, gi}, 32'h01FFFFFF);
        apb(1'b1, ADDR_OVSF, {25'h0000000, ov}, rd, err);
        apb(1'b1, ADDR_CTRL, {25'h0000000, sf, 1'b0, 1'b1, oq, en}, rd, err);
        cfg_sf   = sf;
        cfg_oq   = oq;
        cfg_ovsf = ov;
        cfg_gi   = gi;
        cfg_gen++;
    endtask : start_cfg

    // ====================
    // Reference spreader
    function automatic logic [24:0] lfsr_next(input logic [24:0] s, input logic [24:0] taps);
        return {^(s & taps), s[24:1]};
    endfunction : lfsr_next

    // Built from the root by doubling, negating the copy where the index bit asks
    function automatic logic ovsf_ref(input int k, input logic [6:0] sel,
                                      input logic [2:0] lg);
        logic v;
        v = 1'b1;
        for (int i = 0; i < lg; i++) begin
            if (k[i] && sel[i]) v = ~v;
        end
        return v;
    endfunction : ovsf_ref

    // Follows each fresh chip; a frozen cycle repeats the last one
    always @(posedge clk) begin
        // A new code set restarts the reference; only this process owns its state
        if (m_gen != cfg_gen) begin
            m_gen  = cfg_gen;
            m_s1   = FIRST_INIT;
            m_s2   = cfg_gi;
            m_k    = 0;
            m_par  = 1'b0;
            m_pend = 1'b0;
        end
        if (reset_n && m_ce && chip_valid === 1'b1) begin
            if (m_k == 0) begin
                chk_word("queued", 32'h00000001, 32'(bitq.size() > 0));
                m_bit = (bitq.size() > 0) ? bitq.pop_front() : 1'b0;
            end
            m_exp = ~m_bit ^ m_s1[0] ^ m_s2[0] ^ ovsf_ref(m_k, cfg_ovsf, cfg_sf);
            chk_bit("sym_start", m_k == 0, sym_start);
            chk_bit("chip_bpsk", m_exp, chip_bpsk);
            if (cfg_oq) begin
                if (m_pend) chk_bit("chip_q", m_qexp, chip_q);
                if (!(m_k[0] ^ m_par)) chk_bit("chip_i", m_exp, chip_i);
                m_pend = m_k[0] ^ m_par;
                m_qexp = m_exp;
            end else begin
                chk_bit("chip_i", m_exp, chip_i);
            end
            m_s1 = lfsr_next(m_s1, TAPS_FIRST);
            m_s2 = lfsr_next(m_s2, TAPS_SECOND);
            m_k  = m_k + 1;
            if (m_k == (1 << cfg_sf)) begin
                m_k   = 0;
                m_par = ~m_par;
            end
        end
        if (reset_n && ce && bit_valid && bit_ready) bitq.push_back(bit_data);
        m_ce = ce;
    end

    // ====================
    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite, src_on, ce_rand} = 6'h00;
        paddr    = 12'h000;
        pwdata   = 32'h00000000;
        cfg_sf   = 3'h3;
        cfg_oq   = 1'b0;
        cfg_ovsf = 7'h00;
        void'($urandom(78781));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, then an unmapped place both ways
        rd_chk(ADDR_CTRL, 32'h00000030, 32'hFFFFFFFB);
        rd_chk(ADDR_GINIT, 32'h00000001, 32'hFFFFFFFF);
        rd_chk(ADDR_OVSF, 32'h00000000, 32'hFFFFFFFF);
        rd_chk(ADDR_STATUS, 32'h00000000, 32'h00000F03);
        apb(1'b0, 12'h010, 32'h00000000, rd, err);
        chk_bit("pslverr", 1'b1, err);
        apb(1'b1, 12'h010, 32'h00001234, rd, err);
        chk_bit("pslverr", 1'b1, err);
        rd_chk(ADDR_GINIT, 32'h00000001, 32'hFFFFFFFF);
        // Every spreading factor, both modes, random codes, enable gaps later
        for (int c = 0; c < 8; c++) begin
            start_cfg(c[2:0], c[0], 25'($urandom), 7'($urandom), 1'b1);
            src_on  <= 1'b1;
            ce_rand <= (c >= 4);
            repeat (60) @(posedge clk);
            src_on  <= 1'b0;
            ce_rand <= 1'b0;
            wait_idle();
        end
        // Buffer filled while stopped, then drained without restart
        start_cfg(3'h1, 1'b1, 25'h0ABCDEF, 7'h01, 1'b0);
        src_on <= 1'b1;
        for (int i = 0; i < 40 && bit_ready !== 1'b0; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        src_on <= 1'b0;
        chk_bit("bit_ready", 1'b0, bit_ready);
        chk_word("taken", 32'h00000008, 32'(bitq.size()));
        rd_chk(ADDR_STATUS, 32'h00000800, 32'h00000F00);
        apb(1'b1, ADDR_CTRL, 32'h00000013, rd, err);
        wait_idle();
        chk_word("left", 32'h00000000, 32'(bitq.size()));
        complete_run();
    end
endmodule : tb
